//--- verilog/ddp_pkg.sv
// What this block does
// - two address halves per cycle go out on the memory address lines
// - two bank-address halves per cycle go out on the memory bank lines
// - row, column and write strobes pass as active-low halves to memory
// - chip-select, clock-enable and termination halves go to memory
// - strobe-burst input from the controller steers data strobe enables
// - read data is captured, resynchronised and joined into one word
// - read-valid pulses high for one cycle each time a new word lands on the read-data bus
// - data line output enable comes from beats leaving the write buffer
// - high half drives while command clock is high, low half when low
package ddp_pkg;

  localparam int ROW_W = 13;
  localparam int BANK_W = 3;
  localparam int CS_W = 1;
  localparam int DQ_W = 8;
  localparam int RATIO = 2;
  localparam int DM_W = 1;
  localparam int DQS_W = 1;
  localparam int WORD_W = DQ_W * RATIO;
  localparam int BE_W = DM_W * RATIO;
  localparam int FIFO_DEPTH = 32;

  // reset levels of the memory side pins
  localparam logic CMD_IDLE_N = 1'h1;
  localparam logic OE_OFF_N = 1'h1;
  localparam logic PHASE_LOW = 1'h0;

  // one half of an address/command pair
  typedef struct packed {
    logic [ROW_W-1:0] addr;
    logic [BANK_W-1:0] bank;
    logic rasN;
    logic casN;
    logic weN;
    logic [CS_W-1:0] csN;
    logic [CS_W-1:0] cke;
    logic [CS_W-1:0] odt;
  } ddp_cmd_t;

  // a high/low pair as the controller hands it over
  typedef struct packed {
    ddp_cmd_t hi;
    ddp_cmd_t lo;
  } ddp_cmd_pair_t;

  // one buffered write beat: data word plus byte enables
  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic [BE_W-1:0] be;
  } ddp_wbeat_t;

  localparam ddp_cmd_t CMD_RESET = '{
    addr: '0, bank: '0, rasN: CMD_IDLE_N, casN: CMD_IDLE_N,
    weN: CMD_IDLE_N, csN: '1, cke: '0, odt: '0};

endpackage

//--- verilog/ddp_fifo.sv
`timescale 1ns/1ps
module ddp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic load;

  // full is kept as a flop so the upstream ready is glitch free
  assign push = inValid && inReady;
  assign load = (count != '0) && (!outValid || outReady);
  assign next_count = count + (AW+1)'(push) - (AW+1)'(load);

  // storage array, no reset needed on data
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointers and occupancy
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + AW'(1);
      end
      if (load) begin
        rdPtr <= rdPtr + AW'(1);
      end
      count <= next_count;
      inReady <= (next_count != (AW+1)'(DEPTH));
    end
  end

  // registered output stage; read data comes out of a flop
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      outValid <= 1'b0;
      outData <= '0;
    end else if (load) begin
      outValid <= 1'b1;
      outData <= mem[rdPtr];
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end

endmodule

//--- verilog/ddp_datapath.sv
`timescale 1ns/1ps
module ddp_datapath
  import ddp_pkg::*;
#(
  parameter bit USE_DATA_MASK = 1'b1,
  parameter int WFIFO_DEPTH = FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rstn,
  // controller side
  input wire ddp_cmd_pair_t ctlCmd,
  input wire logic [WORD_W-1:0] ctlWdata,
  input wire logic ctlWdataValid,
  output logic ctlWdataReady,
  input wire logic [BE_W-1:0] writeByteEnables,
  input wire logic ctlDqsBurst,
  output logic [WORD_W-1:0] ctlRdata,
  output logic ctlRdataValid,
  // memory side
  output logic doubleRateCommandClock,
  output ddp_cmd_t memCmd,
  output logic [DM_W-1:0] memoryDataMask,
  output logic [DQ_W-1:0] memDqOut,
  output logic memDqOeN,
  input wire logic [DQ_W-1:0] memDqIn,
  output logic [DQS_W-1:0] memDqsOut,
  output logic memDqsOeN,
  input wire logic [DQS_W-1:0] memDqsIn
);

  logic phase;
  ddp_cmd_t cmdLo;
  ddp_wbeat_t beatIn;
  ddp_wbeat_t beatOut;
  logic beatValid;
  logic beatReady;
  logic [DQ_W-1:0] wLo;
  logic [DM_W-1:0] wLoMask;
  logic [DM_W-1:0] next_mask;
  logic wLoPending;
  logic [DQ_W-1:0] dqS1;
  logic [DQ_W-1:0] dqS2;
  logic dqsS1;
  logic dqsS2;
  logic dqsS3;
  logic rdHiSeen;
  logic [DQ_W-1:0] rdHi;
  logic popNow;

  assign beatIn = '{data: ctlWdata, be: writeByteEnables};
  // beats leave the buffer only at the start of a command-clock high half
  assign beatReady = !phase;
  assign popNow = beatReady && beatValid;

  // write beats queue here so a stalled memory side pushes back
  ddp_fifo #(
    .WIDTH($bits(ddp_wbeat_t)),
    .DEPTH(WFIFO_DEPTH)
  ) u_wfifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .inValid(ctlWdataValid),
    .inData(beatIn),
    .inReady(ctlWdataReady),
    .outValid(beatValid),
    .outData(beatOut),
    .outReady(beatReady)
  );

  // divider: command clock is core clock over two, made here, not a domain
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase <= PHASE_LOW;
    end else begin
      phase <= !phase;
    end
  end
  assign doubleRateCommandClock = phase;

  // pair is sampled once per pair slot; low half is parked until needed
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmdLo <= CMD_RESET;
    end else if (!phase) begin
      cmdLo <= ctlCmd.lo;
    end
  end

  // high half while clock high, low half while clock low
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      memCmd <= CMD_RESET;
    end else if (!phase) begin
      memCmd <= ctlCmd.hi;
    end else begin
      memCmd <= cmdLo;
    end
  end

  // write data path: high byte lane first, then the low one
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      memDqOut <= '0;
      memDqOeN <= OE_OFF_N;
      wLo <= '0;
      wLoPending <= 1'b0;
    end else if (popNow) begin
      memDqOut <= beatOut.data[WORD_W-1 -: DQ_W];
      memDqOeN <= 1'b0;
      wLo <= beatOut.data[DQ_W-1:0];
      wLoPending <= 1'b1;
    end else if (wLoPending) begin
      memDqOut <= wLo;
      wLoPending <= 1'b0;
    end else begin
      memDqOeN <= OE_OFF_N;
    end
  end

  // mask is the inverse of the enable; a set mask bit drops the byte
  always_comb begin
    next_mask = '0;
    if (popNow) begin
      next_mask = ~beatOut.be[BE_W-1 -: DM_W];
    end else if (wLoPending) begin
      next_mask = wLoMask;
    end
  end

  generate
    if (USE_DATA_MASK) begin : g_mask
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          memoryDataMask <= '0;
          wLoMask <= '0;
        end else begin
          memoryDataMask <= next_mask;
          if (popNow) begin
            wLoMask <= ~beatOut.be[DM_W-1:0];
          end
        end
      end
    end else begin : g_nomask
      // option off: no mask logic, the pins are left idle
      assign memoryDataMask = '0;
      assign wLoMask = '0;
    end
  endgenerate

  // strobe enables follow the burst control; strobe toggles with the phase
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      memDqsOeN <= OE_OFF_N;
      memDqsOut <= '0;
    end else begin
      memDqsOeN <= !ctlDqsBurst;
      memDqsOut <= {DQS_W{!phase}};
    end
  end

  // two-flop synchronisers on the pin inputs; stage one feeds stage two only
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dqS1 <= '0;
      dqS2 <= '0;
      dqsS1 <= 1'b0;
      dqsS2 <= 1'b0;
      dqsS3 <= 1'b0;
    end else begin
      dqS1 <= memDqIn;
      dqS2 <= dqS1;
      dqsS1 <= memDqsIn[0];
      dqsS2 <= dqsS1;
      dqsS3 <= dqsS2;
    end
  end

  // capture on strobe rise, join on fall; works only for slow strobes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdHi <= '0;
      rdHiSeen <= 1'b0;
      ctlRdata <= '0;
      ctlRdataValid <= 1'b0;
    end else begin
      ctlRdataValid <= 1'b0;
      if (memDqOeN && dqsS2 && !dqsS3) begin
        rdHi <= dqS2;
        rdHiSeen <= 1'b1;
      end else if (memDqOeN && !dqsS2 && dqsS3 && rdHiSeen) begin
        ctlRdata <= {rdHi, dqS2};
        ctlRdataValid <= 1'b1;
        rdHiSeen <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_addr_hi;
    !phase |=> memCmd.addr == $past(ctlCmd.hi.addr);
  endproperty
  a_addr_hi: assert property (p_addr_hi)
    else $error("high address half not driven");

  property p_bank_lo;
    phase |=> memCmd.bank == $past(cmdLo.bank);
  endproperty
  a_bank_lo: assert property (p_bank_lo)
    else $error("low bank half not driven");

  property p_strobes_hi;
    !phase |=> {memCmd.rasN, memCmd.casN, memCmd.weN}
      == $past({ctlCmd.hi.rasN, ctlCmd.hi.casN, ctlCmd.hi.weN});
  endproperty
  a_strobes_hi: assert property (p_strobes_hi)
    else $error("command strobes wrong in high half");

  property p_ctl_lo;
    !phase ##1 phase |=> {memCmd.csN, memCmd.cke, memCmd.odt}
      == $past({ctlCmd.lo.csN, ctlCmd.lo.cke, ctlCmd.lo.odt}, 2);
  endproperty
  a_ctl_lo: assert property (p_ctl_lo)
    else $error("select/enable/termination low half wrong");

  property p_half_align;
    phase |-> memCmd == $past(ctlCmd.hi);
  endproperty
  a_half_align: assert property (p_half_align)
    else $error("high half not aligned to clock high");

  property p_dq_oe;
    popNow |=> !memDqOeN ##1 !memDqOeN;
  endproperty
  a_dq_oe: assert property (p_dq_oe)
    else $error("data enable not held for both halves");

  property p_dq_lanes;
    popNow |=> memDqOut == $past(beatOut.data[WORD_W-1 -: DQ_W])
      ##1 memDqOut == $past(beatOut.data[DQ_W-1:0], 2);
  endproperty
  a_dq_lanes: assert property (p_dq_lanes)
    else $error("write lanes out of order");

  property p_dqs_oe;
    ctlDqsBurst |=> !memDqsOeN;
  endproperty
  a_dqs_oe: assert property (p_dqs_oe)
    else $error("strobe enable ignores burst control");

  property p_mask;
    USE_DATA_MASK && popNow |=>
      memoryDataMask == ~$past(beatOut.be[BE_W-1 -: DM_W]);
  endproperty
  a_mask: assert property (p_mask)
    else $error("mask is not the inverted byte enable");

  property p_nomask;
    !USE_DATA_MASK |-> memoryDataMask == '0;
  endproperty
  a_nomask: assert property (p_nomask)
    else $error("mask pins active with option off");

  property p_rd_valid;
    ctlRdataValid |-> $past(dqsS3) && !$past(dqsS2) && !$past(ctlRdataValid);
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read valid without a completed strobe pair");

  property p_rd_data;
    ctlRdataValid |-> ctlRdata[DQ_W-1:0] == $past(dqS2);
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("read low lane not the captured value");

endmodule

//--- dv/ddp_mem_model.sv
`timescale 1ns/1ps
module ddp_mem_model
  import ddp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rdGo,
  input wire logic [WORD_W-1:0] rdWord,
  output logic [DQS_W-1:0] dqs,
  output logic [DQ_W-1:0] dq
);
  int cnt;
  logic [WORD_W-1:0] word;

  initial begin
    cnt = 0;
    dqs = '0;
    dq = '0;
  end

  // slow strobe: each level held 3 core cycles so the phy sync can see it
  always @(posedge core_clk) begin
    if (cnt == 0 && rdGo) begin
      word = rdWord;
      cnt = 6;
    end
    if (cnt > 0) begin
      dqs <= {DQS_W{cnt > 3}};
      dq <= (cnt > 3) ? word[WORD_W-1 -: DQ_W] : word[DQ_W-1:0];
      cnt = cnt - 1;
    end else begin
      // released: strobe pulled low, data wanders so stale bytes never match
      dqs <= '0;
      dq <= ~dq;
    end
  end
endmodule

//--- dv/ddp_datapath_bench.sv
`timescale 1ns/1ps
module ddp_datapath_bench
  import ddp_pkg::*;
;
  logic core_clk = 1'b0, rstn = 1'b0;
  ddp_cmd_pair_t ctlCmd = '0;
  logic [WORD_W-1:0] ctlWdata = '0, ctlRdata, rdWord = '0;
  logic ctlWdataValid = 1'b0, ctlWdataReady, ctlDqsBurst = 1'b0;
  logic [BE_W-1:0] writeByteEnables = '0;
  logic ctlRdataValid, doubleRateCommandClock, memDqOeN, memDqsOeN;
  logic rdGo = 1'b0, burstQ = 1'b0, phaseQ = 1'b0;
  logic [DM_W-1:0] maskOff;
  ddp_cmd_t memCmd;
  logic [DM_W-1:0] memoryDataMask;
  logic [DQ_W-1:0] memDqOut, memDqIn;
  logic [DQS_W-1:0] memDqsOut, memDqsIn;
  int badCount = 0, testsRun = 0, seed = 32'hA2B3;
  logic [8:0] wq[$];
  logic [WORD_W-1:0] rq[$];

  ddp_datapath i_ddp_datapath (.core_clk(core_clk), .rstn(rstn),
    .ctlCmd(ctlCmd), .ctlWdata(ctlWdata), .ctlWdataValid(ctlWdataValid),
    .ctlWdataReady(ctlWdataReady), .writeByteEnables(writeByteEnables),
    .ctlDqsBurst(ctlDqsBurst), .ctlRdata(ctlRdata),
    .ctlRdataValid(ctlRdataValid),
    .doubleRateCommandClock(doubleRateCommandClock), .memCmd(memCmd),
    .memoryDataMask(memoryDataMask), .memDqOut(memDqOut),
    .memDqOeN(memDqOeN), .memDqIn(memDqIn), .memDqsOut(memDqsOut),
    .memDqsOeN(memDqsOeN), .memDqsIn(memDqsIn));

  // second build with the mask option off; only its mask pins are watched
  if (1) begin : g_nomask
    ddp_datapath #(.USE_DATA_MASK(1'b0)) i_ddp_datapath (
      .core_clk(core_clk), .rstn(rstn), .ctlCmd(ctlCmd),
      .ctlWdata(ctlWdata), .ctlWdataValid(ctlWdataValid),
      .ctlWdataReady(), .writeByteEnables(writeByteEnables),
      .ctlDqsBurst(ctlDqsBurst), .ctlRdata(), .ctlRdataValid(),
      .doubleRateCommandClock(), .memCmd(), .memoryDataMask(maskOff),
      .memDqOut(), .memDqOeN(), .memDqIn(memDqIn), .memDqsOut(),
      .memDqsOeN(), .memDqsIn(memDqsIn));
  end

  ddp_mem_model i_ddp_mem_model (.core_clk(core_clk), .rdGo(rdGo),
    .rdWord(rdWord), .dqs(memDqsIn), .dq(memDqIn));

  always #12.5 core_clk = ~core_clk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task stopTest;
    $display("comparisons %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // strobe enable follows the burst input, one cycle late
  // held clear in reset, where the enable sits at its idle level
  always @(posedge core_clk) burstQ <= (rstn === 1'b1) && ctlDqsBurst;
  // command clock runs at half the core rate from the first edge out of reset
  always @(posedge core_clk) phaseQ <= (rstn === 1'b1) ? !phaseQ : 1'b0;
  always @(negedge core_clk) ctlDqsBurst <= 1'($random(seed));

  // reference model: pending write lanes and read words, in order
  always @(negedge core_clk) begin
    if (rstn === 1'b1) begin
      check(memDqsOeN, !burstQ);
      check(memDqsOut, phaseQ);
      check(doubleRateCommandClock, phaseQ);
      check(maskOff, 0);
      if (memDqOeN === 1'b0)
        check(wq.size() > 0 ? {memoryDataMask, memDqOut} ^ wq.pop_front()
          : 9'h1FF, 0);
      if (ctlRdataValid === 1'b1)
        check(rq.size() > 0 ? ctlRdata ^ rq.pop_front()
          : 16'hFFFF, 0);
    end
  end

  // a hang counts against the run
  initial begin
    repeat (20000) @(posedge core_clk);
    badCount++;
    stopTest;
  end

  initial begin : mainSeq
    logic [63:0] r;
    ddp_cmd_pair_t p;
    logic [WORD_W-1:0] d;
    logic [BE_W-1:0] be;
    int refused, k;
    logic taken;
    repeat (4) @(negedge core_clk);
    check(memCmd, CMD_RESET);
    check({memDqOeN, ctlRdataValid, ctlWdataReady}, 3'h4);
    rstn = 1'b1;
    // back-to-back pairs, each held for its whole slot
    for (int i = 0; i < 8; i++) begin
      k = 0;
      while (doubleRateCommandClock !== 1'b0 && k < 4) begin
        @(negedge core_clk);
        k++;
      end
      r = {$random(seed), $random(seed)};
      p = r[$bits(ddp_cmd_pair_t)-1:0];
      ctlCmd = p;
      @(negedge core_clk);
      check(memCmd, p.hi);
      check(doubleRateCommandClock, 1);
      @(negedge core_clk);
      check(memCmd, p.lo);
      check(doubleRateCommandClock, 0);
    end
    $display("command pair test done");
    // fill the write buffer until it refuses, then let it drain
    taken = 1'b1;
    refused = 0;
    for (int i = 0; i < 90; i++) begin
      @(negedge core_clk);
      if (taken) begin
        d = WORD_W'($random(seed));
        be = BE_W'($random(seed));
      end
      ctlWdata = d;
      writeByteEnables = be;
      ctlWdataValid = 1'b1;
      taken = (ctlWdataReady === 1'b1);
      if (taken) begin
        wq.push_back({~be[1], d[15:8]});
        wq.push_back({~be[0], d[7:0]});
      end else
        refused++;
    end
    @(negedge core_clk);
    ctlWdataValid = 1'b0;
    check(refused > 0, 1);
    k = 0;
    while (wq.size() > 0 && k < 300) begin
      @(negedge core_clk);
      k++;
    end
    repeat (4) @(negedge core_clk);
    check(wq.size(), 0);
    $display("write buffer test done");
    // reads only while the data lines are released
    for (int i = 0; i < 6; i++) begin
      @(negedge core_clk);
      rdWord = WORD_W'($random(seed));
      rq.push_back(rdWord);
      rdGo = 1'b1;
      @(negedge core_clk);
      rdGo = 1'b0;
      k = 0;
      while (rq.size() > 0 && k < 30) begin
        @(negedge core_clk);
        k++;
      end
      check(rq.size(), 0);
      repeat (3) @(negedge core_clk);
    end
    $display("read capture test done");
    stopTest;
  end
endmodule
